// >>> tsr_pkg.sv
package tsr_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STATE = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_SERIAL_LO = 8'h10;
  localparam logic [7:0] OFS_SERIAL_HI = 8'h14;
  localparam logic [7:0] OFS_MEM_LOCK = 8'h18;
  localparam logic [7:0] OFS_DIAG = 8'h1C;

  // Command modes of the tag status command
  localparam logic [7:0] MODE_IDENT = 8'h01;
  localparam logic [7:0] MODE_DIAG = 8'h02;

  // Memory type codes, and the strap encoding of ferroelectric size
  localparam logic [7:0] MEM_NO_FRAM = 8'h01;
  localparam logic [7:0] MEM_FRAM_8K = 8'h02;
  localparam logic [7:0] MEM_FRAM_32K = 8'h03;
  localparam logic [1:0] FRAM_SEL_NONE = 2'h0;
  localparam logic [1:0] FRAM_SEL_8K = 2'h1;

  // Tag memory location of the lock-bit register
  localparam logic [15:0] LOCK_REG_ADDR = 16'hFF18;

  // Field strength: below this value the transfer is reliable
  localparam logic [7:0] FIELD_OK_LIMIT = 8'h28;
  localparam logic [7:0] CNT_MAX = 8'hFF;

  // Dwell time step
  localparam int CLK_PERIOD_NS = 10;
  localparam int DWELL_STEP_NS = 10_000_000;
  localparam int DWELL_STEP_CYC = DWELL_STEP_NS / CLK_PERIOD_NS;

  // Interrupt status and mask bit positions
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REJECT = 1;
  localparam int IRQ_WEAK = 2;
  localparam int IRQ_LEFT = 3;

  // State register bit positions
  localparam int ST_TAG = 0;
  localparam int ST_ANT = 1;
  localparam int ST_FIELD_OK = 2;
  localparam int ST_MODE_LO = 8;

  // Mode-one answer
  typedef struct packed {
    logic [63:0] serial;
    logic [7:0] mem_type;
    logic [7:0] lock;
  } ident_t;

  // Mode-two answer
  typedef struct packed {
    logic [7:0] field;
    logic [7:0] idle;
    logic [7:0] active;
    logic [7:0] dwell;
  } diag_t;

  // Ferroelectric size strap to memory type code
  function automatic logic [7:0] mem_code(input logic [1:0] sel);
    logic [7:0] c;
    c = MEM_FRAM_32K;
    if (sel == FRAM_SEL_NONE) begin
      c = MEM_NO_FRAM;
    end else if (sel == FRAM_SEL_8K) begin
      c = MEM_FRAM_8K;
    end
    return c;
  endfunction

endpackage

// >>> sat_counter.sv
`timescale 1ns/10ps
module sat_counter #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic clear_in,
  input wire logic inc_in,
  output logic [WIDTH-1:0] count_out
);

  logic [WIDTH-1:0] count_r;

  // Clear beats increment; holds at all ones instead of wrapping
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_r <= '0;
    end else if (clear_in) begin
      count_r <= '0;
    end else if (inc_in && (count_r != {WIDTH{1'b1}})) begin
      count_r <= count_r + WIDTH'(1);
    end
  end

  assign count_out = count_r;

endmodule

// >>> transponder_status_readout.sv
// Operation
// RQ1 - Command mode one answers identity and memory, mode two answers diagnostics.
// RQ2 - Serial is 64 bits: tag identifier low 32 bits, upper 32 bits zero.
// RQ3 - Memory type byte: 01 none, 02 8 KB, 03 32 KB ferroelectric.
// RQ4 - Lock byte is copied from the tag lock-bit register location.
// RQ5 - Mode two gives field value and three counters, each one byte.
// RQ6 - All diagnostic values clear when tag leaves or antenna goes off.
// RQ7 - Lower field value means stronger field; below threshold is reliable.
// RQ8 - Idle fault count increments on fault pulses outside tag communication.
// RQ9 - Active error count increments on errors during tag communication.
// RQ10 - Dwell count advances once per 10 ms step while tag present.
// RQ11 - Byte counters saturate at 255 until cleared.
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
module transponder_status_readout
  import tsr_pkg::*;
#(
  parameter int STEP_CYC = DWELL_STEP_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  input wire logic tag_present_in,
  input wire logic antenna_on_in,
  input wire logic [31:0] tag_serial_in,
  input wire logic [1:0] fram_size_in,
  input wire logic [7:0] lock_data_in,
  output logic [15:0] lock_addr_out,
  input wire logic [7:0] field_strength_value_in,
  input wire logic comm_active_in,
  input wire logic fault_pulse_in,
  input wire logic comm_error_in,
  output logic resp_valid_out,
  output logic [7:0] resp_mode_out,
  output ident_t ident_out,
  output diag_t diag_out,
  output logic irq_out
);

  logic field_clear;
  logic cmd_wr;
  logic cmd_ok;
  logic dwell_tick;
  logic [31:0] step_cnt_r;
  logic [7:0] field_r;
  logic [7:0] idle_fault_count;
  logic [7:0] active_error_count;
  logic [7:0] dwell_time_count;
  logic [2:0] cnt_inc;
  logic [7:0] cnt_val [3];
  logic tag_prev_r;
  logic weak_prev_r;
  logic field_weak;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_stat_nxt;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [7:0] last_mode_r;
  logic resp_valid_r;
  logic [7:0] resp_mode_r;
  ident_t ident_r;
  diag_t diag_r;
  diag_t diag_live;
  logic [15:0] lock_addr_r;
  logic [DATA_W-1:0] rdata_r;

  // Counters and field value are meaningless without a tag in a live field
  assign field_clear = !tag_present_in || !antenna_on_in; // [RQ6]

  // Command register write with a supported mode
  assign cmd_wr = wr_in && (addr_in == OFS_CMD);
  assign cmd_ok = cmd_wr && !field_clear &&
                  ((wdata_in[7:0] == MODE_IDENT) || (wdata_in[7:0] == MODE_DIAG)); // [RQ1]

  // Dwell prescaler; restarts with every new tag so steps align to entry
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      step_cnt_r <= '0;
    end else if (field_clear || dwell_tick) begin
      step_cnt_r <= '0;
    end else begin
      step_cnt_r <= step_cnt_r + 32'h0000_0001;
    end
  end
  assign dwell_tick = !field_clear && (step_cnt_r == 32'(STEP_CYC - 1)); // [RQ10]

  // Field value follows the tag, zero while no tag is in the field
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      field_r <= '0;
    end else if (field_clear) begin
      field_r <= '0; // [RQ6]
    end else begin
      field_r <= field_strength_value_in; // [RQ5]
    end
  end

  // Increment sources for the three byte counters
  assign cnt_inc[0] = fault_pulse_in && !comm_active_in; // [RQ8]
  assign cnt_inc[1] = comm_error_in && comm_active_in; // [RQ9]
  assign cnt_inc[2] = dwell_tick; // [RQ10]

  // One saturating counter per diagnostic count
  generate
    for (genvar i = 0; i < 3; i++) begin : g_cnt
      sat_counter #(
        .WIDTH(8)
      ) u_cnt (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .clear_in(field_clear), // [RQ6]
        .inc_in(cnt_inc[i]), // [RQ11]
        .count_out(cnt_val[i])
      );
    end
  endgenerate

  assign idle_fault_count = cnt_val[0];
  assign active_error_count = cnt_val[1];
  assign dwell_time_count = cnt_val[2];

  // Live diagnostic view, sampled into the answer on a mode-two command
  always_comb begin
    diag_live.field = field_r;
    diag_live.idle = idle_fault_count;
    diag_live.active = active_error_count;
    diag_live.dwell = dwell_time_count;
  end

  // Weak field: value at or above limit, since low values mean strong field
  assign field_weak = !field_clear && (field_r >= FIELD_OK_LIMIT); // [RQ7]

  // Edge history for the tag-left and weak-field events
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tag_prev_r <= 1'b0;
      weak_prev_r <= 1'b0;
    end else begin
      tag_prev_r <= !field_clear;
      weak_prev_r <= field_weak;
    end
  end

  // Interrupt events
  always_comb begin
    irq_ev = '0;
    irq_ev[IRQ_DONE] = cmd_ok;
    irq_ev[IRQ_REJECT] = cmd_wr && !cmd_ok;
    irq_ev[IRQ_WEAK] = field_weak && !weak_prev_r; // [RQ7]
    irq_ev[IRQ_LEFT] = tag_prev_r && field_clear;
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (wr_in && (addr_in == OFS_IRQ_STAT)) begin
      irq_stat_nxt = irq_stat_r & ~wdata_in[IRQ_W-1:0];
    end
    irq_stat_nxt = irq_stat_nxt | irq_ev;
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // Interrupt mask
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_mask_r <= '0;
    end else if (wr_in && (addr_in == OFS_IRQ_MASK)) begin
      irq_mask_r <= wdata_in[IRQ_W-1:0];
    end
  end

  assign irq_out = |(irq_stat_r & irq_mask_r);

  // Answer capture; rejected commands leave the previous answer in place
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      resp_valid_r <= 1'b0;
      resp_mode_r <= '0;
      last_mode_r <= '0;
      ident_r <= '0;
      diag_r <= '0;
    end else begin
      resp_valid_r <= cmd_ok;
      if (cmd_ok) begin
        resp_mode_r <= wdata_in[7:0];
        last_mode_r <= wdata_in[7:0];
        if (wdata_in[7:0] == MODE_IDENT) begin
          ident_r.serial <= {32'h0000_0000, tag_serial_in}; // [RQ2]
          ident_r.mem_type <= mem_code(fram_size_in); // [RQ3]
          ident_r.lock <= lock_data_in; // [RQ4]
        end else begin
          diag_r <= diag_live; // [RQ5]
        end
      end
    end
  end

  // Lock-bit location presented to the tag memory side
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lock_addr_r <= LOCK_REG_ADDR; // [RQ4]
    end else begin
      lock_addr_r <= LOCK_REG_ADDR;
    end
  end

  assign resp_valid_out = resp_valid_r;
  assign resp_mode_out = resp_mode_r;
  assign ident_out = ident_r;
  assign diag_out = diag_r;
  assign lock_addr_out = lock_addr_r;

  // Read data stand one cycle after the strobe and read zero otherwise
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_r <= '0;
    end else if (rd_in) begin
      case (addr_in)
        OFS_CMD: rdata_r <= {24'h00_0000, last_mode_r};
        OFS_STATE: rdata_r <= {16'h0000, resp_mode_r, 5'h00, !field_weak && !field_clear,
                               antenna_on_in, tag_present_in};
        OFS_IRQ_STAT: rdata_r <= {{(DATA_W-IRQ_W){1'b0}}, irq_stat_r};
        OFS_IRQ_MASK: rdata_r <= {{(DATA_W-IRQ_W){1'b0}}, irq_mask_r};
        OFS_SERIAL_LO: rdata_r <= ident_r.serial[31:0];
        OFS_SERIAL_HI: rdata_r <= ident_r.serial[63:32];
        OFS_MEM_LOCK: rdata_r <= {16'h0000, ident_r.mem_type, ident_r.lock};
        OFS_DIAG: rdata_r <= diag_r;
        default: rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  assign rdata_out = rdata_r;

  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  AST_MODE_SELECT: assert property ( // [RQ1]
    cmd_ok |=> resp_valid_out && (resp_mode_out == $past(wdata_in[7:0])))
    else $error("answer mode does not follow command mode");

  AST_SERIAL_LAYOUT: assert property ( // [RQ2]
    (cmd_ok && (wdata_in[7:0] == MODE_IDENT)) |=>
      (ident_out.serial == {32'h0000_0000, $past(tag_serial_in)}))
    else $error("serial layout wrong");

  AST_MEM_CODE: assert property ( // [RQ3]
    (cmd_ok && (wdata_in[7:0] == MODE_IDENT)) |=>
      (ident_out.mem_type == (($past(fram_size_in) == FRAM_SEL_NONE) ? MEM_NO_FRAM :
                              ($past(fram_size_in) == FRAM_SEL_8K) ? MEM_FRAM_8K : MEM_FRAM_32K)))
    else $error("memory type code wrong");

  AST_LOCK_COPY: assert property ( // [RQ4]
    (cmd_ok && (wdata_in[7:0] == MODE_IDENT)) |=>
      (ident_out.lock == $past(lock_data_in)) && (lock_addr_out == LOCK_REG_ADDR))
    else $error("lock byte not copied");

  AST_DIAG_SNAPSHOT: assert property ( // [RQ5]
    (cmd_ok && (wdata_in[7:0] == MODE_DIAG)) |=> (diag_out == $past(diag_live)))
    else $error("diagnostic answer not sampled");

  AST_CLEAR: assert property ( // [RQ6]
    field_clear |=> (diag_live == '0) && (step_cnt_r == '0))
    else $error("diagnostics not cleared");

  AST_WEAK_EVENT: assert property ( // [RQ7]
    (!field_clear && !weak_prev_r && (field_r >= FIELD_OK_LIMIT)) |=> irq_stat_r[IRQ_WEAK])
    else $error("weak field not flagged");

  AST_IDLE_INC: assert property ( // [RQ8]
    (!field_clear && fault_pulse_in && !comm_active_in && (idle_fault_count != CNT_MAX)) |=>
      (idle_fault_count == $past(idle_fault_count) + 8'h01))
    else $error("idle fault not counted");

  AST_ACTIVE_INC: assert property ( // [RQ9]
    (!field_clear && !(comm_error_in && comm_active_in)) |=>
      (active_error_count == $past(active_error_count)))
    else $error("active error count moved without cause");

  AST_DWELL_STEP: assert property ( // [RQ10]
    (!field_clear && !dwell_tick) |=> (dwell_time_count == $past(dwell_time_count)))
    else $error("dwell count moved off step");

  AST_SATURATE: assert property ( // [RQ11]
    (!field_clear && (idle_fault_count == CNT_MAX)) |=> (idle_fault_count == CNT_MAX))
    else $error("counter wrapped");

  COV_IDENT: cover property (cmd_ok && (wdata_in[7:0] == MODE_IDENT) ##1 resp_valid_out);
  COV_DIAG: cover property (cmd_ok && (wdata_in[7:0] == MODE_DIAG) ##1 resp_valid_out);
  COV_LEFT: cover property (irq_ev[IRQ_LEFT] ##1 irq_out);
  COV_REJECT: cover property (cmd_wr && !cmd_ok);

endmodule

// >>> host_model.sv
`timescale 1ns/10ps
module host_model
  import tsr_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic [DATA_W-1:0] rdata_in,
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  // Bus idles with both strobes low
  initial begin
    addr_out = 8'h00;
    wdata_out = 32'h0000_0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // One-cycle write; a command is a mode byte written to the command register
  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge sys_clk_in);
    wr_out <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so sample it there
  task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge sys_clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge sys_clk_in);
    rd_out <= 1'b0;
    #1;
    d = rdata_in;
  endtask
endmodule

// >>> tb_transponder_status_readout.sv
`timescale 1ns/10ps
module tb_transponder_status_readout;
  import tsr_pkg::*;
  logic sys_clk_in, rstn_in, wr, rd, tag, ant, act, fault, err, resp_valid, irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, d;
  logic [31:0] serial;
  logic [1:0] fsize;
  logic [7:0] lock, field, resp_mode;
  logic [15:0] lock_addr;
  ident_t ident;
  diag_t diag;
  int n_fail, n_checks;
  logic [7:0] mem_exp [4] = '{MEM_NO_FRAM, MEM_FRAM_8K, MEM_FRAM_32K, MEM_FRAM_32K};

  host_model i_host (.sys_clk_in(sys_clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd));

  // Short dwell step keeps the saturation run brief
  transponder_status_readout #(.STEP_CYC(4)) i_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .tag_present_in(tag), .antenna_on_in(ant), .tag_serial_in(serial), .fram_size_in(fsize),
    .lock_data_in(lock), .lock_addr_out(lock_addr), .field_strength_value_in(field),
    .comm_active_in(act), .fault_pulse_in(fault), .comm_error_in(err), .resp_valid_out(resp_valid),
    .resp_mode_out(resp_mode), .ident_out(ident), .diag_out(diag), .irq_out(irq));

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Command and answer strobe one cycle later
  task automatic cmd(input logic [7:0] mode, input logic exp_valid);
    i_host.write_reg(OFS_CMD, {24'h00_0000, mode});
    #1;
    chk(resp_valid, exp_valid);
  endtask

  // Fault or error pulses, one cycle each, with the busy level beside them
  task automatic pulses(input logic is_err, input logic busy, input int n);
    repeat (n) begin
      @(posedge sys_clk_in);
      act <= busy;
      fault <= !is_err;
      err <= is_err;
      @(posedge sys_clk_in);
      fault <= 1'b0;
      err <= 1'b0;
    end
    act <= 1'b0;
  endtask

  task automatic s_reset();
    chk(lock_addr, LOCK_REG_ADDR);
    i_host.read_reg(OFS_IRQ_MASK, d);
    chk(d, 32'h0000_0000);
    i_host.read_reg(8'h20, d);
    chk(d, 32'h0000_0000);
  endtask

  // Every memory strap, lock byte changing each time
  task automatic s_ident();
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_in);
      fsize <= i[1:0];
      lock <= 8'h5A ^ i[7:0];
      cmd(MODE_IDENT, 1'b1);
      chk(resp_mode, MODE_IDENT);
      chk(ident.serial, {32'h0000_0000, serial});
      chk(ident.mem_type, mem_exp[i]);
      chk(ident.lock, 8'h5A ^ i[7:0]);
    end
    i_host.read_reg(OFS_SERIAL_HI, d);
    chk(d, 32'h0000_0000);
    i_host.read_reg(OFS_SERIAL_LO, d);
    chk(d, serial);
    i_host.read_reg(OFS_MEM_LOCK, d);
    chk(d, {16'h0000, MEM_FRAM_32K, 8'h5A ^ 8'h03});
  endtask

  // Pulses of the wrong kind for the busy level must not count
  task automatic s_counts();
    @(posedge sys_clk_in);
    tag <= 1'b0;
    field <= 8'h30;
    @(posedge sys_clk_in);
    tag <= 1'b1;
    pulses(1'b0, 1'b0, 260);
    pulses(1'b0, 1'b1, 3);
    pulses(1'b1, 1'b1, 2);
    pulses(1'b1, 1'b0, 2);
    repeat (600) @(posedge sys_clk_in);
    cmd(MODE_DIAG, 1'b1);
    chk(diag, {8'h30, 8'hFF, 8'h02, 8'hFF});
    i_host.read_reg(OFS_DIAG, d);
    chk(d, {8'h30, 8'hFF, 8'h02, 8'hFF});
  endtask

  // Tag leaving, then antenna off, each wipes the counters
  task automatic s_clear();
    for (int k = 0; k < 2; k++) begin
      pulses(1'b0, 1'b0, 3);
      @(posedge sys_clk_in);
      tag <= (k != 0);
      ant <= (k == 0);
      repeat (2) @(posedge sys_clk_in);
      tag <= 1'b1;
      ant <= 1'b1;
      cmd(MODE_DIAG, 1'b1);
      chk(diag[23:0], 24'h00_0000);
      // Three fresh idle faults, and two dwell steps since the tag came back
      pulses(1'b0, 1'b0, 3);
      cmd(MODE_DIAG, 1'b1);
      chk(diag[23:0], {8'h03, 8'h00, 8'h02});
    end
  endtask

  // Threshold edge of the field value
  task automatic s_field();
    for (int v = 0; v < 2; v++) begin
      @(posedge sys_clk_in);
      field <= FIELD_OK_LIMIT - 8'h01 + v[7:0];
      repeat (3) @(posedge sys_clk_in);
      i_host.read_reg(OFS_STATE, d);
      chk(d[ST_FIELD_OK], v == 0);
    end
  endtask

  // Refused commands, masking and write-one-to-clear
  task automatic s_irq();
    i_host.write_reg(OFS_IRQ_STAT, 32'h0000_000F);
    cmd(8'h03, 1'b0);
    @(posedge sys_clk_in);
    #1;
    chk(irq, 1'b0);
    i_host.write_reg(OFS_IRQ_MASK, 32'h0000_0002);
    #1;
    chk(irq, 1'b1);
    i_host.read_reg(OFS_IRQ_STAT, d);
    chk(d[IRQ_REJECT], 1'b1);
    i_host.write_reg(OFS_IRQ_STAT, 32'h0000_0002);
    #1;
    chk(irq, 1'b0);
    @(posedge sys_clk_in);
    tag <= 1'b0;
    lock <= 8'hC3;
    cmd(MODE_IDENT, 1'b0);
    chk(ident.lock, 8'h5A ^ 8'h03);
  endtask

  // Bounded run: a hang counts as a mismatch
  initial begin
    #200_000;
    n_fail++;
    final_report();
  end

  initial begin
    rstn_in = 1'b0;
    tag = 1'b1;
    ant = 1'b1;
    act = 1'b0;
    fault = 1'b0;
    err = 1'b0;
    serial = 32'hA5C3_1E07;
    fsize = 2'h0;
    lock = 8'h00;
    field = 8'h10;
    n_fail = 0;
    n_checks = 0;
    repeat (6) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    s_reset();
    s_ident();
    s_counts();
    s_clear();
    s_field();
    s_irq();
    final_report();
  end
endmodule
